// ==== bench/pes_src_model.sv ====
// Model of the on-chip error sources feeding the status block.
`timescale 1ns/100ps
module pes_src_model (
  input wire logic hclk,
  input wire logic [16:0] level,
  output pes_pkg::pes_src_t src_err
);
  // Sources are plain levels launched after an edge, so they change only just after a rising hclk edge.
  always_ff @(posedge hclk)
  begin
    src_err <= level;
  end
endmodule

// ==== bench/pes_status_tb_top.sv ====
// Testbench for the second platform error status block.
`timescale 1ns/100ps
`include "pes_consts.svh"
module pes_status_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [16:0] level = 17'h0;
  logic [31:0] hrdata, jtag_mirror, rd, exp;
  logic hreadyout, hresp, irq;
  pes_pkg::pes_src_t src_err;
  int num_errors = 0;
  int samples_checked = 0;
  int pos [17] = '{0, 1, 2, 3, 4, 5, 6, 17, 18, 19, 22, 23, 24, 25, 26, 27, 28};
  logic [31:0] ed [5] = '{32'hffff_ffff, 32'h0, 32'h1800_0001, 32'h0, 32'h1};
  logic [31:0] em [5] = '{32'h0, 32'h0, 32'h1800_0001, 32'h1800_0001, 32'h1800_0000};
  always #2 hclk = ~hclk;
  pes_src_model src (.hclk(hclk), .level(level), .src_err(src_err));
  pes_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_err(src_err), .jtag_mirror(jtag_mirror), .irq(irq));
  // ----
  // Tasks.
  // ----
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Bounded wait for ready, so a stuck slave ends the run instead of hanging it.
  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      num_errors++;
      $display("mismatch at %0t: no hready", $time);
      report_and_stop();
    end
  endtask
  // One single transfer; read data are taken at the data-phase edge.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  function automatic logic [31:0] rev(input logic [31:0] v);
    for (int i = 0; i < 32; i++)
      rev[i] = v[31 - i];
  endfunction
  // ----
  // Sequence.
  // ----
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `PES_OFF_STATUS, 32'h0);
    check(rd, 32'h0020_0000);
    check(jtag_mirror, 32'h0000_0400);
    bus(1'b0, `PES_OFF_MASK, 32'h0);
    check(rd, 32'h1fce_007f);
    check({31'h0, hresp}, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    $display("test reset done");
    // Every source alone, with all masked, must still show raw.
    for (int i = 0; i < 17; i++)
    begin
      level <= 17'h1_0000 >> i;
      repeat (6) @(posedge hclk);
      exp = 32'h0020_0000 | (32'h1 << pos[i]);
      bus(1'b0, `PES_OFF_STATUS, 32'h0);
      check(rd, exp);
      check(jtag_mirror, rev(exp));
    end
    bus(1'b1, `PES_OFF_STATUS, 32'h0);
    bus(1'b0, `PES_OFF_STATUS, 32'h0);
    check(rd, exp);
    level <= 17'h0;
    $display("test sources done");
    // Enable and disable writes; zeros change nothing.
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, (i % 2) ? `PES_OFF_DISABLE : `PES_OFF_ENABLE, ed[i]);
      if (i == 2)
        bus(1'b1, `PES_OFF_DISABLE, ed[i]);
      bus(1'b0, `PES_OFF_MASK, 32'h0);
      check(rd, em[i]);
    end
    $display("test mask done");
    // Bit 0 unmasked, bit 28 masked: only bit 0 may latch an event.
    level <= 17'h1_0001;
    repeat (6) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, `PES_OFF_EVMASK, 32'h1);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    bus(1'b0, `PES_OFF_EVENT, 32'h0);
    check(rd, 32'h1);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, `PES_OFF_EVENT, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 32'h0000_0020, 32'h0);
    check(rd, 32'h0);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule

// ==== rtl/pes_consts.svh ====
// Constants for the second platform error status block.
`ifndef PES_CONSTS_SVH
`define PES_CONSTS_SVH

// -----------------------------------------------------------------------------
// Register byte offsets.
// -----------------------------------------------------------------------------
`define PES_OFF_STATUS 32'h0000_0000
`define PES_OFF_MASK 32'h0000_0004
`define PES_OFF_ENABLE 32'h0000_0008
`define PES_OFF_DISABLE 32'h0000_000c
`define PES_OFF_EVENT 32'h0000_0010
`define PES_OFF_EVMASK 32'h0000_0014

// -----------------------------------------------------------------------------
// Status bit positions.
// -----------------------------------------------------------------------------
`define PES_B_DECODE 0
`define PES_B_ROM 1
`define PES_B_RECOV 2
`define PES_B_PROT 3
`define PES_B_PARITY 4
`define PES_B_CORR 5
`define PES_B_NCORR 6
`define PES_B_CFG_NCR 17
`define PES_B_CRC 18
`define PES_B_ECC 19
`define PES_B_RSV0 20
`define PES_B_RSV1 21
`define PES_B_RTC 22
`define PES_B_PLL1 23
`define PES_B_PLL2 24
`define PES_B_CLKMON 25
`define PES_B_TIMEOUT 26
`define PES_B_MPU 27
`define PES_B_PPU 28

// Valid source bits: 0-6, 17-19, 22-28.
`define PES_SRC_BITS 32'h1fce_007f
`define PES_MASK_RESET 32'h1fce_007f
`define PES_RESP_OKAY 1'b0
`endif

// ==== rtl/pes_pkg.sv ====
// Types for the second platform error status block.
package pes_pkg;
  // One indication per documented source.
  typedef struct packed {
    logic decode_err;
    logic rom_err;
    logic recov_err;
    logic prot_err;
    logic parity_err;
    logic corr_err;
    logic ncorr_err;
    logic cfg_ncr_err;
    logic crc_err;
    logic ecc_err;
    logic rtc_alarm;
    logic pll1_unlocked;
    logic pll2_unlocked;
    logic clkmon_err;
    logic timeout_err;
    logic mpu_err;
    logic ppu_err;
  } pes_src_t;

  // Bus slave states.
  typedef enum logic [1:0] {
    PES_IDLE = 2'b01,
    PES_DATA = 2'b10
  } pes_state_t;
endpackage

// ==== rtl/pes_status.sv ====
// Second platform error status register bank with AHB-Lite slave.
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "pes_consts.svh"

module pes_status (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pes_pkg::pes_src_t src_err,
  output logic [31:0] jtag_mirror,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // Source synchronisers.
  // ---------------------------------------------------------------------------

  // Sources come from other units and may be asynchronous, so three stages.
  logic [31:0] raw;
  logic [31:0] s1;
  logic [31:0] s2;
  logic [31:0] s3;
  logic [31:0] status;

  // Map each source to its fixed position; reserved bits stay zero here.
  always_comb
  begin
    raw = 32'h0000_0000;
    raw[`PES_B_DECODE] = src_err.decode_err;
    raw[`PES_B_ROM] = src_err.rom_err;
    raw[`PES_B_RECOV] = src_err.recov_err;
    raw[`PES_B_PROT] = src_err.prot_err;
    raw[`PES_B_PARITY] = src_err.parity_err;
    raw[`PES_B_CORR] = src_err.corr_err;
    raw[`PES_B_NCORR] = src_err.ncorr_err;
    raw[`PES_B_CFG_NCR] = src_err.cfg_ncr_err;
    raw[`PES_B_CRC] = src_err.crc_err;
    raw[`PES_B_ECC] = src_err.ecc_err;
    raw[`PES_B_RTC] = src_err.rtc_alarm;
    raw[`PES_B_PLL1] = src_err.pll1_unlocked;
    raw[`PES_B_PLL2] = src_err.pll2_unlocked;
    raw[`PES_B_CLKMON] = src_err.clkmon_err;
    raw[`PES_B_TIMEOUT] = src_err.timeout_err;
    raw[`PES_B_MPU] = src_err.mpu_err;
    raw[`PES_B_PPU] = src_err.ppu_err;
  end

  // Three-stage pipe; only the second stage reads the first.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1 <= 32'h0000_0000;
      s2 <= 32'h0000_0000;
      s3 <= 32'h0000_0000;
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit changes only once stages two and three agree, filtering glitches.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status <= 32'h0000_0000;
    else
      status <= ((status & (s2 ^ s3)) | (s3 & ~(s2 ^ s3))) & `PES_SRC_BITS;
  end

  // Status value as software sees it: raw, unmasked, reserved bits forced.
  logic [31:0] status_view;
  assign status_view = (status & `PES_SRC_BITS) | (32'h1 << `PES_B_RSV1);

  // JTAG mirror is the status word bit-reversed, so bit 0 lands on bit 31.
  function automatic logic [31:0] pes_reverse(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++)
      r[31 - i] = v[i];
    return r;
  endfunction

  // Mirror is registered so the scan view never shows a half-settled word.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      jtag_mirror <= 32'h0000_0000;
    else
      jtag_mirror <= pes_reverse(status_view);
  end

  // ---------------------------------------------------------------------------
  // AHB-Lite slave.
  // ---------------------------------------------------------------------------

  pes_pkg::pes_state_t state;
  logic [31:0] addr_q;
  logic write_q;
  logic [31:0] mask;
  logic [31:0] event_flags;
  logic [31:0] evmask;
  logic take;
  logic wr_en;
  logic rd_en;

  // Every slave answers with zero wait states.
  assign take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = `PES_RESP_OKAY;
  assign wr_en = (state == pes_pkg::PES_DATA) && write_q;
  assign rd_en = take && !hwrite;

  // Capture the address phase for the following data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= pes_pkg::PES_IDLE;
      addr_q <= 32'h0000_0000;
      write_q <= 1'b0;
    end
    else
    begin
      state <= take ? pes_pkg::PES_DATA : pes_pkg::PES_IDLE;
      if (take)
      begin
        addr_q <= haddr;
        write_q <= hwrite;
      end
    end
  end

  // Mask: enable writes clear bits, disable writes set them; zeros ignored.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask <= `PES_MASK_RESET;
    else if (wr_en && addr_q == `PES_OFF_ENABLE)
      mask <= mask & ~(hwdata & `PES_SRC_BITS);
    else if (wr_en && addr_q == `PES_OFF_DISABLE)
      mask <= mask | (hwdata & `PES_SRC_BITS);
  end

  // Interrupt mask over the sticky event flags, written directly.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      evmask <= 32'h0000_0000;
    else if (wr_en && addr_q == `PES_OFF_EVMASK)
      evmask <= hwdata & `PES_SRC_BITS;
  end

  // Sticky events catch rising status; a new rise beats the read clear.
  logic [31:0] rises;
  logic [31:0] prev_status;
  assign rises = status & ~prev_status & ~mask;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_status <= 32'h0000_0000;
      event_flags <= 32'h0000_0000;
    end
    else
    begin
      prev_status <= status;
      if (rd_en && haddr == `PES_OFF_EVENT)
        event_flags <= rises;
      else
        event_flags <= event_flags | rises;
    end
  end

  // Interrupt is high while an unmasked event flag stands.
  assign irq = |(event_flags & evmask);

  // Read data registered at the address phase for the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      unique case (haddr)
        `PES_OFF_STATUS: hrdata <= status_view;
        `PES_OFF_MASK: hrdata <= mask;
        `PES_OFF_EVENT: hrdata <= event_flags;
        `PES_OFF_EVMASK: hrdata <= evmask;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Assertion sequences.
  // ---------------------------------------------------------------------------

  // Five samples cover the three sync stages and the agreement stage, so a
  // level held that long is certain to have reached the status word.
  sequence s_pll1_held;
    raw[`PES_B_PLL1] [*5];
  endsequence

  sequence s_pll2_clear;
    !src_err.pll2_unlocked [*5];
  endsequence

  // The scan mirror is registered once more, so it needs one sample extra.
  sequence s_decode_held;
    src_err.decode_err [*6];
  endsequence

  sequence s_crc_held;
    src_err.crc_err [*5];
  endsequence

  sequence s_timeout_held;
    src_err.timeout_err [*5];
  endsequence

  sequence s_ppu_held;
    src_err.ppu_err [*5];
  endsequence

  sequence s_parity_held;
    src_err.parity_err [*5];
  endsequence

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------

  a_rsv_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    status_view[31:29] == 3'h0 && status_view[20] == 1'b0 && status_view[21] == 1'b1)
    else $error("reserved status bits wrong");

  a_pll1_raw: assert property (@(posedge hclk) disable iff (!hresetn)
    s_pll1_held |-> status_view[`PES_B_PLL1])
    else $error("first pll unlock not shown");

  a_pll2_raw: assert property (@(posedge hclk) disable iff (!hresetn)
    s_pll2_clear |-> !status_view[`PES_B_PLL2])
    else $error("second pll bit stuck");

  a_decode_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    s_decode_held |-> jtag_mirror[31])
    else $error("decode error mirror wrong");

  a_mask_raw: assert property (@(posedge hclk) disable iff (!hresetn)
    s_crc_held |-> status_view[`PES_B_CRC])
    else $error("crc bit masked");

  a_enable_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_en && addr_q == `PES_OFF_ENABLE && hwdata[`PES_B_ECC]) |=> !mask[`PES_B_ECC])
    else $error("enable did not clear mask");

  a_disable_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_en && addr_q == `PES_OFF_DISABLE && hwdata[`PES_B_MPU]) |=> mask[`PES_B_MPU])
    else $error("disable did not set mask");

  a_zero_nop: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_en && addr_q == `PES_OFF_ENABLE && !hwdata[`PES_B_PPU]) |=> $stable(mask[`PES_B_PPU]))
    else $error("enable zero changed mask");

  a_timeout_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    s_timeout_held |-> status_view[`PES_B_TIMEOUT])
    else $error("timeout bit missing");

  a_ppu_raw: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ppu_held |-> status_view[`PES_B_PPU])
    else $error("peripheral protection bit missing");

  a_parity_raw: assert property (@(posedge hclk) disable iff (!hresetn)
    s_parity_held |-> status_view[`PES_B_PARITY])
    else $error("parity bit missing");

  a_mirror_map: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> jtag_mirror == pes_reverse($past(status_view)))
    else $error("scan mirror does not follow status");

  a_rsv_low: assert property (@(posedge hclk) disable iff (!hresetn)
    status_view[16:7] == 10'h000)
    else $error("reserved middle bits not zero");

  a_masked_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> (event_flags & ~$past(event_flags) & $past(mask)) == 32'h0000_0000)
    else $error("masked source raised an event");

  a_enable_event: assert property (@(posedge hclk) disable iff (!hresetn)
    rises[`PES_B_DECODE] |=> event_flags[`PES_B_DECODE])
    else $error("enabled source did not raise an event");

  a_filter_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> ((status ^ $past(status)) & ($past(s2) ^ $past(s3))) == 32'h0000_0000)
    else $error("status moved while stages disagree");

  a_filter_take: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> ((status ^ $past(s3)) & ~($past(s2) ^ $past(s3)) & `PES_SRC_BITS) == 32'h0000_0000)
    else $error("status missed an agreed source level");

endmodule
